// ===== rtl/pcs_top.sv
// Configuration source, strap pins, status pins and register port of the PHY
`timescale 1ns/1ps
module pcs_top
#(
	parameter int P_DATA_W = pcs_pkg::PCS_DATA_W
)
(
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic              i_hardware_reset_n,
	input  wire logic              i_config_source_select,
	input  wire logic              i_speed_select,
	output logic                   o_speed_select,
	output logic                   o_speed_select_oe,
	input  wire logic              i_autoneg_select,
	output logic                   o_autoneg_select,
	output logic                   o_autoneg_select_oe,
	input  wire logic              i_duplex_select,
	output logic                   o_duplex_select,
	output logic                   o_duplex_select_oe,
	input  wire logic              i_auto_crossover_enable,
	input  wire logic              i_auto_crossover_driven,
	input  wire logic              i_interface_format_select,
	input  wire logic              i_node_repeater_select,
	input  wire logic              i_scrambler_locked,
	input  wire logic              i_link_up,
	input  wire logic              i_rx_activity,
	input  wire logic              i_tx_activity,
	output logic                   o_scrambler_lock,
	output logic                   o_link_status_out,
	output logic                   o_carrier_sense,
	output logic                   o_speed_100,
	output logic                   o_autoneg_enable,
	output logic                   o_full_duplex,
	output logic                   o_auto_crossover,
	output logic                   o_if_mii,
	output logic                   o_if_symbol,
	output logic                   o_if_serial,
	output logic                   o_repeater_mode,
	output logic                   o_sqe_test_enable,
	output logic                   o_operational,
	input  wire pcs_pkg::pcs_addr_t i_addr,
	input  wire logic [P_DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic [P_DATA_W-1:0]    o_rdata
);
	import pcs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	generate
		if (P_DATA_W < PCS_STAT_W)
		begin : g_bad_width
			$error("pcs_top: data width too narrow for status word");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Pin level in hardware mode, register value in software mode
	function automatic logic sel_cfg
	(
		input logic sw_mode,
		input logic pin_level,
		input logic reg_value
	);
		sel_cfg = (sw_mode == PCS_MODE_SW) ? reg_value : pin_level;
	endfunction

	function automatic logic addr_hit
	(
		input pcs_addr_t addr,
		input pcs_addr_t ofs
	);
		addr_hit = (addr == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic                   core_rst;
	logic [PCS_CTRL_W-1:0]  ctrl;
	logic [PCS_CTRL_W-1:0]  next_ctrl;
	logic                   mode_sw;
	logic                   next_mode_sw;
	logic                   speed_100;
	logic                   next_speed_100;
	logic                   autoneg_en;
	logic                   next_autoneg_en;
	logic                   full_dpx;
	logic                   next_full_dpx;
	logic                   xover_en;
	logic                   next_xover_en;
	logic                   if_format;
	logic                   next_if_format;
	logic                   repeater;
	logic                   next_repeater;
	logic [2:0]             pin_val;
	logic [2:0]             next_pin_val;
	logic                   pin_oe;
	logic                   next_pin_oe;
	logic                   locked;
	logic                   next_locked;
	logic                   link;
	logic                   next_link;
	logic                   running;
	logic                   next_running;
	logic [PCS_STAT_W-1:0]  stat_word;
	logic [P_DATA_W-1:0]    rdata;
	logic [P_DATA_W-1:0]    next_rdata;

	pcs_cs_if cs ();

	// Hardware reset pin acts as a second synchronous reset
	assign core_rst = i_rst || !i_hardware_reset_n;

	////////////////////////////////////////////////////////////////////////////////
	// Control register: follows the straps in hardware mode
	always_comb
	begin
		next_ctrl = ctrl;
		if (i_config_source_select == PCS_MODE_HW)
		begin
			next_ctrl[PCS_CTRL_SPEED] = i_speed_select;
			next_ctrl[PCS_CTRL_AN]    = i_autoneg_select;
			next_ctrl[PCS_CTRL_DPX]   = i_duplex_select;
		end
		else if (i_wr && addr_hit(i_addr, PCS_CTRL_OFS))
		begin
			next_ctrl = i_wdata[PCS_CTRL_W-1:0];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (core_rst)
		begin
			ctrl <= PCS_CTRL_RST;
		end
		else
		begin
			ctrl <= next_ctrl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Effective configuration, in step with the control register and the pins
	always_comb
	begin
		next_mode_sw    = i_config_source_select;
		next_speed_100  = sel_cfg(i_config_source_select, i_speed_select,
			next_ctrl[PCS_CTRL_SPEED]);
		next_autoneg_en = sel_cfg(i_config_source_select, i_autoneg_select,
			next_ctrl[PCS_CTRL_AN]);
		next_full_dpx   = sel_cfg(i_config_source_select, i_duplex_select,
			next_ctrl[PCS_CTRL_DPX]);
		// Internal pull-up: undriven input reads asserted
		next_xover_en   = i_auto_crossover_driven ? i_auto_crossover_enable
			: 1'h1;
		next_if_format  = i_interface_format_select;
		next_repeater   = i_node_repeater_select;
	end

	always_ff @(posedge i_clk)
	begin
		if (core_rst)
		begin
			mode_sw    <= PCS_MODE_HW;
			speed_100  <= PCS_CTRL_RST[PCS_CTRL_SPEED];
			autoneg_en <= PCS_CTRL_RST[PCS_CTRL_AN];
			full_dpx   <= PCS_CTRL_RST[PCS_CTRL_DPX];
			xover_en   <= 1'h1;
			if_format  <= PCS_IF_MII;
			repeater   <= 1'h0;
		end
		else
		begin
			mode_sw    <= next_mode_sw;
			speed_100  <= next_speed_100;
			autoneg_en <= next_autoneg_en;
			full_dpx   <= next_full_dpx;
			xover_en   <= next_xover_en;
			if_format  <= next_if_format;
			repeater   <= next_repeater;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Select pins: released in hardware mode, driven from control in software mode
	always_comb
	begin
		next_pin_oe  = (i_config_source_select == PCS_MODE_SW);
		next_pin_val = 3'h0;
		if (next_pin_oe)
		begin
			next_pin_val[PCS_CTRL_SPEED] = next_ctrl[PCS_CTRL_SPEED];
			next_pin_val[PCS_CTRL_AN]    = next_ctrl[PCS_CTRL_AN];
			// Low for half duplex, high for full duplex
			next_pin_val[PCS_CTRL_DPX]   = next_ctrl[PCS_CTRL_DPX];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (core_rst)
		begin
			pin_oe  <= 1'h0;
			pin_val <= 3'h0;
		end
		else
		begin
			pin_oe  <= next_pin_oe;
			pin_val <= next_pin_val;
		end
	end

	assign o_speed_select      = pin_val[PCS_CTRL_SPEED];
	assign o_speed_select_oe   = pin_oe;
	assign o_autoneg_select    = pin_val[PCS_CTRL_AN];
	assign o_autoneg_select_oe = pin_oe;
	assign o_duplex_select     = pin_val[PCS_CTRL_DPX];
	assign o_duplex_select_oe  = pin_oe;

	////////////////////////////////////////////////////////////////////////////////
	// Line status and run state
	always_comb
	begin
		next_locked  = i_scrambler_locked;
		next_link    = i_link_up;
		next_running = 1'h1;
	end

	always_ff @(posedge i_clk)
	begin
		if (core_rst)
		begin
			locked  <= 1'h0;
			link    <= 1'h0;
			running <= 1'h0;
		end
		else
		begin
			locked  <= next_locked;
			link    <= next_link;
			running <= next_running;
		end
	end

	assign o_scrambler_lock  = locked;
	assign o_link_status_out = link;
	assign o_operational     = running;

	////////////////////////////////////////////////////////////////////////////////
	// Core-facing configuration
	assign o_speed_100       = speed_100;
	assign o_autoneg_enable  = autoneg_en;
	assign o_full_duplex     = full_dpx;
	assign o_auto_crossover  = xover_en;
	assign o_if_mii          = (if_format == PCS_IF_MII);
	assign o_if_symbol       = (if_format != PCS_IF_MII) && speed_100;
	assign o_if_serial       = (if_format != PCS_IF_MII) && !speed_100;
	assign o_repeater_mode   = (repeater == PCS_ROLE_REP);
	// Node sends the SQE test, repeater suppresses it
	assign o_sqe_test_enable = (repeater != PCS_ROLE_REP) && running;

	////////////////////////////////////////////////////////////////////////////////
	// Carrier sense
	// Gated by reset itself so the first edge after release already counts
	assign cs.rx_activity = i_rx_activity && !core_rst;
	assign cs.tx_activity = i_tx_activity && !core_rst;
	assign cs.half_duplex = !full_dpx;
	assign cs.repeater    = (repeater == PCS_ROLE_REP);

	pcs_csense u_csense
	(
		.i_clk (i_clk),
		.i_rst (core_rst),
		.cs    (cs)
	);

	assign o_carrier_sense = cs.carrier_sense;

	////////////////////////////////////////////////////////////////////////////////
	// Register read port
	always_comb
	begin
		stat_word                 = '0;
		stat_word[PCS_STAT_SW]    = mode_sw;
		stat_word[PCS_STAT_SPEED] = speed_100;
		stat_word[PCS_STAT_AN]    = autoneg_en;
		stat_word[PCS_STAT_DPX]   = full_dpx;
		stat_word[PCS_STAT_XOVER] = xover_en;
		stat_word[PCS_STAT_LOCK]  = locked;
		stat_word[PCS_STAT_LINK]  = link;
		stat_word[PCS_STAT_IFSEL] = if_format;
		stat_word[PCS_STAT_REP]   = repeater;
		stat_word[PCS_STAT_CRS]   = cs.carrier_sense;
		stat_word[PCS_STAT_RUN]   = running;
	end

	always_comb
	begin
		next_rdata = '0;
		if (i_rd)
		begin
			if (addr_hit(i_addr, PCS_CTRL_OFS))
			begin
				next_rdata[PCS_CTRL_W-1:0] = ctrl;
			end
			else if (addr_hit(i_addr, PCS_STAT_OFS))
			begin
				next_rdata[PCS_STAT_W-1:0] = stat_word;
			end
		end
	end

	// Read port stays alive during hardware reset
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			rdata <= '0;
		end
		else
		begin
			rdata <= next_rdata;
		end
	end

	assign o_rdata = rdata;

endmodule

// ===== include/pcs_pkg.sv
// Constants and types of the PHY configuration and strap control block
// Function
// - Configuration source select low gives hardware mode, high gives software mode.
// - Hardware mode: speed select is an input, low 10Base-T, high 100Base-TX.
// - Software mode: speed select driven out, low 10Base-T, high 100Base-TX.
// - Hardware mode: autoneg select is an input, high selects auto-negotiation.
// - Software mode: autoneg select driven out, high while auto-negotiation enabled.
// - Hardware mode: duplex select is an input, low half, high full duplex.
// - Software mode: duplex select driven low while set for half duplex.
// - Auto crossover enable is input only; undriven it reads as asserted.
// - Scrambler lock output high while lock is held, low otherwise.
// - Link status output high while a link is established, low otherwise.
// - Interface format select low configures the MAC-side port as MII.
// - Format select high: symbol interface at 100Base-TX, serial at 10Base-T.
// - Node/repeater select low gives node, high repeater; steers SQE test, carrier.
// - Carrier: half-duplex node on receive or transmit; full duplex/repeater receive only.
// - Device held in reset while hardware reset input is low; the read data register is reset by i_rst only and keeps answering reads.
package pcs_pkg;

	localparam int PCS_ADDR_W      = 8;
	localparam int PCS_DATA_W      = 32;

	typedef logic [PCS_ADDR_W-1:0] pcs_addr_t;

	// Register byte offsets
	localparam pcs_addr_t PCS_CTRL_OFS = 8'h00;
	localparam pcs_addr_t PCS_STAT_OFS = 8'h04;

	// Control register fields
	localparam int PCS_CTRL_SPEED  = 0;
	localparam int PCS_CTRL_AN     = 1;
	localparam int PCS_CTRL_DPX    = 2;
	localparam int PCS_CTRL_W      = 3;
	localparam logic [PCS_CTRL_W-1:0] PCS_CTRL_RST = 3'h7;

	// Status register fields
	localparam int PCS_STAT_SW     = 0;
	localparam int PCS_STAT_SPEED  = 1;
	localparam int PCS_STAT_AN     = 2;
	localparam int PCS_STAT_DPX    = 3;
	localparam int PCS_STAT_XOVER  = 4;
	localparam int PCS_STAT_LOCK   = 5;
	localparam int PCS_STAT_LINK   = 6;
	localparam int PCS_STAT_IFSEL  = 7;
	localparam int PCS_STAT_REP    = 8;
	localparam int PCS_STAT_CRS    = 9;
	localparam int PCS_STAT_RUN    = 10;
	localparam int PCS_STAT_W      = 11;

	// Pin levels
	localparam logic PCS_MODE_HW   = 1'h0;
	localparam logic PCS_MODE_SW   = 1'h1;
	localparam logic PCS_IF_MII    = 1'h0;
	localparam logic PCS_ROLE_REP  = 1'h1;

endpackage

// ===== include/pcs_cs_if.sv
// Carrier sense signals between the configuration core and the carrier logic
`timescale 1ns/1ps
interface pcs_cs_if;
	logic rx_activity;
	logic tx_activity;
	logic half_duplex;
	logic repeater;
	logic carrier_sense;

	modport cfg
	(
		output rx_activity,
		output tx_activity,
		output half_duplex,
		output repeater,
		input  carrier_sense
	);

	modport sense
	(
		input  rx_activity,
		input  tx_activity,
		input  half_duplex,
		input  repeater,
		output carrier_sense
	);
endinterface

// ===== rtl/pcs_csense.sv
// Carrier sense generation from duplex and node/repeater setting
`timescale 1ns/1ps
module pcs_csense
(
	input  wire logic i_clk,
	input  wire logic i_rst,
	pcs_cs_if.sense   cs
);
	import pcs_pkg::*;

	logic crs;
	logic next_crs;

	////////////////////////////////////////////////////////////////////////////////
	// Transmit activity counts only for a half-duplex node
	always_comb
	begin
		next_crs = cs.rx_activity;
		if (cs.half_duplex && !cs.repeater)
		begin
			next_crs = cs.rx_activity || cs.tx_activity;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			crs <= 1'h0;
		end
		else
		begin
			crs <= next_crs;
		end
	end

	assign cs.carrier_sense = crs;

endmodule

// ===== verif/pcs_board_model.sv
// Board straps and crossover pull-up around the strap pins
`timescale 1ns/1ps
module pcs_board_model
(
	input  wire logic [2:0] i_strap,
	input  wire logic [2:0] i_dev_val,
	input  wire logic [2:0] i_dev_oe,
	input  wire logic       i_xover_driven,
	input  wire logic       i_xover_level,
	output logic [2:0]      o_pin,
	output logic            o_xover
);
	// Weak straps lose to the device wherever it drives
	assign o_pin = (i_dev_oe & i_dev_val) | (~i_dev_oe & i_strap);
	assign o_xover = i_xover_driven ? i_xover_level : 1'b1;
endmodule

// ===== verif/pcs_top_sva.sv
// Assertion checker on the strap control top ports
`timescale 1ns/1ps
module pcs_top_sva
#(
	parameter int P_DATA_W = pcs_pkg::PCS_DATA_W
)
(
	input  wire logic                i_clk,
	input  wire logic                i_rst,
	input  wire logic                i_hardware_reset_n,
	input  wire logic                i_config_source_select,
	input  wire logic                i_speed_select,
	input  wire logic                i_autoneg_select,
	input  wire logic                i_duplex_select,
	input  wire logic                i_wr,
	input  wire logic                i_rd,
	input  wire logic                i_auto_crossover_enable,
	input  wire logic                i_auto_crossover_driven,
	input  wire logic                i_interface_format_select,
	input  wire logic                i_node_repeater_select,
	input  wire logic                i_scrambler_locked,
	input  wire logic                i_link_up,
	input  wire logic                i_rx_activity,
	input  wire logic                i_tx_activity,
	input  wire logic                o_speed_select,
	input  wire logic                o_speed_select_oe,
	input  wire logic                o_autoneg_select,
	input  wire logic                o_autoneg_select_oe,
	input  wire logic                o_duplex_select,
	input  wire logic                o_duplex_select_oe,
	input  wire logic                o_scrambler_lock,
	input  wire logic                o_link_status_out,
	input  wire logic                o_carrier_sense,
	input  wire logic                o_speed_100,
	input  wire logic                o_autoneg_enable,
	input  wire logic                o_full_duplex,
	input  wire logic                o_auto_crossover,
	input  wire logic                o_if_mii,
	input  wire logic                o_if_symbol,
	input  wire logic                o_if_serial,
	input  wire logic                o_repeater_mode,
	input  wire logic                o_sqe_test_enable,
	input  wire logic                o_operational,
	input  wire logic [P_DATA_W-1:0] o_rdata
);
	logic ok;
	assign ok = i_hardware_reset_n && !i_rst;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_sw_idle;
		ok && i_config_source_select && !i_wr;
	endsequence
	sequence s_cfg_steady;
		$stable(o_full_duplex) && $stable(o_repeater_mode);
	endsequence
	//////////////////////////////////////////////////////////////////////
	a_mode_oe: assert property ({o_speed_select_oe, o_autoneg_select_oe, o_duplex_select_oe}
		== {3{$past(ok && i_config_source_select)}}) else $error("pin enable wrong");
	a_hw_straps: assert property ($past(ok && !i_config_source_select) |->
		{o_full_duplex, o_autoneg_enable, o_speed_100} ==
		$past({i_duplex_select, i_autoneg_select, i_speed_select})) else $error("strap lost");
	a_sw_pins: assert property (o_speed_select_oe |->
		{o_duplex_select, o_autoneg_select, o_speed_select} ==
		{o_full_duplex, o_autoneg_enable, o_speed_100}) else $error("pin shows wrong");
	a_sw_hold: assert property (s_sw_idle ##1 s_sw_idle |=>
		$stable({o_duplex_select, o_autoneg_select, o_speed_select})) else $error("pin moved");
	a_xover_pull: assert property (o_auto_crossover ==
		$past(!ok || !i_auto_crossover_driven || i_auto_crossover_enable))
		else $error("crossover wrong");
	a_lock_copy: assert property (o_scrambler_lock == $past(ok && i_scrambler_locked))
		else $error("lock wrong");
	a_link_copy: assert property (o_link_status_out == $past(ok && i_link_up))
		else $error("link wrong");
	a_if_format: assert property (o_if_mii == $past(!(ok && i_interface_format_select))
		&& o_if_symbol == (!o_if_mii && o_speed_100) && o_if_serial == (!o_if_mii
		&& !o_speed_100)) else $error("format wrong");
	a_role_sqe: assert property (o_repeater_mode == $past(ok && i_node_repeater_select)
		&& o_sqe_test_enable == (!o_repeater_mode && o_operational)) else $error("role wrong");
	a_carrier: assert property (s_cfg_steady |-> o_carrier_sense == $past(ok
		&& (i_rx_activity || i_tx_activity && !o_full_duplex && !o_repeater_mode)))
		else $error("carrier wrong");
	a_run_state: assert property (o_operational == $past(ok)) else $error("run wrong");
	a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == '0) else $error("rdata stuck");
endmodule
bind pcs_top pcs_top_sva #(.P_DATA_W(P_DATA_W)) i_pcs_top_sva (.*);

// ===== verif/pcs_top_tb.sv
// Self-checking bench of the strap control top with a reference model
`timescale 1ns/1ps
module pcs_top_tb;
	import pcs_pkg::*;
	logic i_clk = 0, i_rst = 1, hwn = 1, sel = 0, fmt = 0, nrs = 0, lck = 0, lnk = 0;
	logic rx = 0, tx = 0, xd = 1, xl = 1, wr = 0, rd = 0, xo_p;
	logic [2:0] strap = 0, pin, ctrl;
	pcs_addr_t addr = 0;
	logic [31:0] wd = 0, rdat, e_rd;
	logic sp_o, sp_e, an_o, an_e, dx_o, dx_e, lk_o, ln_o, cs_o, s100, ane, fdx, xov;
	logic mii, sym, ser, rep_o, sqe, op_o;
	logic e_oe, e_lk, e_ln, e_cs, e_rep, e_fmt, e_x, e_op, r, ofd, orep;
	integer seed = 32'ha0b93f9a, errors = 0, n_tests = 0, i;
	always #12.5 i_clk = ~i_clk;
	pcs_top i_pcs_top (.i_clk(i_clk), .i_rst(i_rst), .i_hardware_reset_n(hwn),
		.i_config_source_select(sel), .i_speed_select(pin[0]), .o_speed_select(sp_o),
		.o_speed_select_oe(sp_e), .i_autoneg_select(pin[1]), .o_autoneg_select(an_o),
		.o_autoneg_select_oe(an_e), .i_duplex_select(pin[2]), .o_duplex_select(dx_o),
		.o_duplex_select_oe(dx_e), .i_auto_crossover_enable(xo_p),
		.i_auto_crossover_driven(xd), .i_interface_format_select(fmt),
		.i_node_repeater_select(nrs), .i_scrambler_locked(lck), .i_link_up(lnk),
		.i_rx_activity(rx), .i_tx_activity(tx), .o_scrambler_lock(lk_o),
		.o_link_status_out(ln_o), .o_carrier_sense(cs_o), .o_speed_100(s100),
		.o_autoneg_enable(ane), .o_full_duplex(fdx), .o_auto_crossover(xov),
		.o_if_mii(mii), .o_if_symbol(sym), .o_if_serial(ser), .o_repeater_mode(rep_o),
		.o_sqe_test_enable(sqe), .o_operational(op_o), .i_addr(addr), .i_wdata(wd),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdat));
	pcs_board_model i_pcs_board_model (.i_strap(strap), .i_dev_val({dx_o, an_o, sp_o}),
		.i_dev_oe({dx_e, an_e, sp_e}), .i_xover_driven(xd), .i_xover_level(xl),
		.o_pin(pin), .o_xover(xo_p));
	//////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task bus(input logic w, input logic rq, input pcs_addr_t a, input logic [31:0] d);
		@(posedge i_clk);
		wr <= w;
		rd <= rq;
		addr <= a;
		wd <= d;
	endtask
	task test_done;
		if (errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Reference model, sampled before the edge's own updates land
	always @(posedge i_clk)
	begin
		r = i_rst | ~hwn;
		ofd = ctrl[2];
		orep = e_rep;
		e_rd = (i_rst || !rd) ? 0 : addr == PCS_CTRL_OFS ? ctrl : addr == PCS_STAT_OFS ?
			{e_op, e_cs, e_rep, e_fmt, e_ln, e_lk, e_x, ctrl, e_oe} : 0;
		if (r)
		begin
			ctrl = 3'h7;
			{e_oe, e_lk, e_ln, e_cs, e_rep, e_fmt, e_op} = 0;
			e_x = 1;
		end
		else
		begin
			if (!sel)
				ctrl = pin;
			else if (wr && addr == PCS_CTRL_OFS)
				ctrl = wd[2:0];
			e_cs = rx | tx & !ofd & !orep;
			{e_oe, e_lk, e_ln, e_rep, e_fmt, e_op, e_x} = {sel, lck, lnk, nrs, fmt, 1'b1, xo_p};
		end
		#1;
		chk({sp_e, an_e, dx_e}, {3{e_oe}});
		if (e_oe) chk({dx_o, an_o, sp_o}, ctrl);
		chk({fdx, ane, s100}, ctrl);
		chk(xov, e_x);
		chk(lk_o, e_lk);
		chk(ln_o, e_ln);
		chk(mii, !e_fmt);
		chk({sym, ser}, {e_fmt & ctrl[0], e_fmt & !ctrl[0]});
		chk({rep_o, sqe}, {e_rep, !e_rep & e_op});
		chk(cs_o, e_cs);
		chk(op_o, e_op);
		chk(rdat, e_rd);
	end
	initial
	begin
		repeat (10) @(posedge i_clk);
		i_rst <= 0;
		for (i = 0; i < 600; i++)
		begin
			@(posedge i_clk);
			if ($random(seed) % 8 == 0) sel <= ~sel;
			strap <= $random(seed);
			{fmt, nrs, lck, lnk, rx, tx, xd, xl} <= $random(seed);
			hwn <= ($random(seed) % 16) != 0;
			i_rst <= (i == 300);
			wr <= $random(seed);
			addr <= $random(seed) & 8'h0c;
			wd <= $random(seed);
		end
		@(posedge i_clk);
		hwn <= 1;
		sel <= 1;
		for (i = 0; i < 8; i++)
		begin
			bus(1, 0, PCS_CTRL_OFS, i);
			bus(0, 1, PCS_CTRL_OFS, 0);
		end
		bus(1, 0, PCS_STAT_OFS, '1);
		bus(0, 1, PCS_STAT_OFS, 0);
		bus(0, 1, 8'h10, 0);
		sel <= 0;
		bus(1, 0, PCS_CTRL_OFS, {29'h0, ~strap});
		bus(0, 1, PCS_CTRL_OFS, 0);
		bus(0, 0, 0, 0);
		bus(0, 0, 0, 0);
		test_done;
	end
endmodule
